// File: boot_defines.vh
// constants of the boot-time configuration mode controller
`ifndef BOOT_DEFINES_VH
`define BOOT_DEFINES_VH
`define MODE_NONE 2'h0
`define MODE_OTP 2'h1
`define MODE_MASTER 2'h2
`define MODE_SLAVE 2'h3
`define ST_IDLE 3'h0
`define ST_SAMPLE 3'h1
`define ST_LOAD 3'h2
`define ST_WAKE 3'h3
`define ST_USER 3'h4
`define WAKE_CYCLES 6'h31
`define SLOW_DIV 4'h4
`define FAST_DIV 4'h1
`endif

// File: pin_sync.v
// two flip-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
module pin_sync #(
  parameter RESET_VAL = 1'b0
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire d_i,
  output reg q_o
);
  reg meta_r;
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // reset to the pin's idle level so no false edge follows reset
      meta_r <= RESET_VAL;
      q_o <= RESET_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// File: config_mode_select_boot.v
// boot configuration controller: strap sampling, mode choice, done and wake-up
`timescale 1ns/100ps
`include "boot_defines.vh"
module config_mode_select_boot #(
  parameter HAS_OTP = 1'b1,
  parameter WAKE_COUNT = `WAKE_CYCLES
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire supplies_ok_i,
  input wire config_reset_n_i,
  input wire strap_cs_i,
  output reg strap_cs_o,
  output reg strap_cs_oe_o,
  output reg strap_pullup_o,
  input wire otp_enabled_i,
  input wire otp_secured_i,
  output reg otp_load_o,
  input wire otp_load_done_i,
  input wire otp_read_req_i,
  output reg otp_read_allow_o,
  input wire prog_cmd_valid_i,
  output reg prog_cmd_accept_o,
  output reg flash_sck_o,
  input wire flash_load_done_i,
  input wire fast_osc_req_i,
  input wire host_sck_i,
  input wire slave_load_done_i,
  output reg [1:0] mode_o,
  output reg cfg_clk_o,
  output reg config_complete_flag_o,
  output reg config_complete_flag_oe_o,
  output reg user_io_pins_en_o
);
  // ************************************************
  // synchronisers for pins from outside the clock domain
  // ************************************************
  wire creset_s;
  wire strap_s;
  wire sck_s;
  wire pwr_s;
  // reset pin reads as asserted until two clocks have passed
  pin_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_rst (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(config_reset_n_i),
    .q_o(creset_s)
  );
  // strap idles high like its pull-up
  pin_sync #(
    .RESET_VAL(1'b1)
  ) u_sync_strap (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(strap_cs_i),
    .q_o(strap_s)
  );
  // host clock idles low, matching the edge detector's reset value
  pin_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_sck (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(host_sck_i),
    .q_o(sck_s)
  );
  pin_sync #(
    .RESET_VAL(1'b0)
  ) u_sync_pwr (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .d_i(supplies_ok_i),
    .q_o(pwr_s)
  );

  // ************************************************
  // state and local signals
  // ************************************************
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg [5:0] wake_r;
  reg [3:0] div_r;
  reg fast_r;
  reg sck_q_r;
  reg sck_int_r;
  wire sck_rise;
  wire osc_tick;
  wire cfg_tick;
  wire [3:0] div_lim;
  wire run_ok;
  wire load_done;

  assign run_ok = creset_s & pwr_s;
  assign sck_rise = sck_s & ~sck_q_r;
  assign div_lim = fast_r ? `FAST_DIV : `SLOW_DIV;
  assign osc_tick = (div_r == div_lim - 4'h1);
  // one tick per full clock: host rising edges, or oscillator low-to-high toggles
  assign cfg_tick = (mode_r == `MODE_SLAVE) ? sck_rise : (osc_tick & ~sck_int_r);
  assign load_done = (mode_r == `MODE_OTP) ? otp_load_done_i :
                     (mode_r == `MODE_MASTER) ? flash_load_done_i :
                     (mode_r == `MODE_SLAVE) ? slave_load_done_i : 1'b0;

  // ************************************************
  // oscillator divider: toggling each half period keeps 50% duty
  // ************************************************
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 4'h0;
      sck_int_r <= 1'b0;
      sck_q_r <= 1'b0;
      fast_r <= 1'b0;
    end else begin
      sck_q_r <= sck_s;
      if (!run_ok) begin
        fast_r <= 1'b0;
        div_r <= 4'h0;
        sck_int_r <= 1'b0;
      end else begin
        if (state_r == `ST_LOAD && fast_osc_req_i) begin
          fast_r <= 1'b1;
        end
        if (osc_tick) begin
          div_r <= 4'h0;
          sck_int_r <= ~sck_int_r;
        end else begin
          div_r <= div_r + 4'h1;
        end
      end
    end
  end

  // ************************************************
  // mode selection state machine
  // ************************************************
  always @* begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    case (state_r)
      `ST_IDLE: begin
        if (run_ok) begin
          state_nxt = `ST_SAMPLE;
        end
      end
      `ST_SAMPLE: begin
        state_nxt = `ST_LOAD;
        if (!strap_s) begin
          mode_nxt = `MODE_SLAVE;
        end else if (HAS_OTP && otp_enabled_i) begin
          mode_nxt = `MODE_OTP;
        end else begin
          mode_nxt = `MODE_MASTER;
        end
      end
      `ST_LOAD: begin
        if (load_done) begin
          state_nxt = `ST_WAKE;
        end
      end
      `ST_WAKE: begin
        if (cfg_tick && wake_r == WAKE_COUNT - 6'd1) begin
          state_nxt = `ST_USER;
        end
      end
      `ST_USER: begin
        state_nxt = `ST_USER;
      end
      default: begin
        state_nxt = `ST_IDLE;
      end
    endcase
  end

  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= `ST_IDLE;
      mode_r <= `MODE_NONE;
      wake_r <= 6'd0;
    end else if (!run_ok) begin
      // reset pin low returns everything to cold-boot state
      state_r <= `ST_IDLE;
      mode_r <= `MODE_NONE;
      wake_r <= 6'd0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      if (state_r == `ST_WAKE && cfg_tick) begin
        wake_r <= wake_r + 6'd1;
      end else if (state_r != `ST_WAKE) begin
        wake_r <= 6'd0;
      end
    end
  end

  // ************************************************
  // registered outputs
  // ************************************************
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_cs_o <= 1'b1;
      strap_cs_oe_o <= 1'b0;
      strap_pullup_o <= 1'b1;
      otp_load_o <= 1'b0;
      otp_read_allow_o <= 1'b0;
      prog_cmd_accept_o <= 1'b0;
      flash_sck_o <= 1'b0;
      mode_o <= `MODE_NONE;
      cfg_clk_o <= 1'b0;
      config_complete_flag_o <= 1'b0;
      config_complete_flag_oe_o <= 1'b1;
      user_io_pins_en_o <= 1'b0;
    end else begin
      strap_pullup_o <= 1'b1;
      // master drives select low during load; otherwise it is an input
      strap_cs_oe_o <= (mode_r == `MODE_MASTER) && (state_r == `ST_LOAD);
      strap_cs_o <= ~((mode_r == `MODE_MASTER) && (state_r == `ST_LOAD));
      otp_load_o <= (mode_r == `MODE_OTP) && (state_r == `ST_LOAD);
      otp_read_allow_o <= otp_read_req_i && !otp_secured_i;
      // programming commands only in slave mode while unconfigured
      prog_cmd_accept_o <= prog_cmd_valid_i && (mode_r == `MODE_SLAVE) && (state_r == `ST_LOAD);
      flash_sck_o <= (mode_r == `MODE_MASTER) && (state_r == `ST_LOAD) && sck_int_r;
      cfg_clk_o <= (mode_r == `MODE_SLAVE) ? sck_s : sck_int_r;
      mode_o <= mode_r;
      // pull-down released once loading finishes
      config_complete_flag_o <= 1'b0;
      config_complete_flag_oe_o <= !(state_r == `ST_WAKE || state_r == `ST_USER);
      user_io_pins_en_o <= (state_r == `ST_USER);
    end
  end
endmodule

// File: boot_cfg_properties.sv
// checker on the boot controller ports
`timescale 1ns/100ps
module boot_cfg_props (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire otp_read_req_i,
  input wire otp_secured_i,
  input wire strap_cs_o,
  input wire strap_cs_oe_o,
  input wire strap_pullup_o,
  input wire otp_read_allow_o,
  input wire otp_load_o,
  input wire prog_cmd_accept_o,
  input wire cfg_clk_o,
  input wire [1:0] mode_o,
  input wire config_complete_flag_o,
  input wire config_complete_flag_oe_o,
  input wire user_io_pins_en_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  reg clk_q_r;
  reg [5:0] rise_cnt_r;
  // counts configuration clock rises since the done pin was released
  always @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      clk_q_r <= 1'b0;
      rise_cnt_r <= 6'h00;
    end else begin
      clk_q_r <= cfg_clk_o;
      if (config_complete_flag_oe_o) begin
        rise_cnt_r <= 6'h00;
      end else if (cfg_clk_o && !clk_q_r && rise_cnt_r != 6'h3F) begin
        rise_cnt_r <= rise_cnt_r + 6'h01;
      end
    end
  end
  AST_WAKE_COUNT: assert property ($rose(user_io_pins_en_o) |-> rise_cnt_r >= 6'h2F) else $error("short wake");
  AST_OTP_LOAD: assert property (otp_load_o |-> mode_o == 2'h1 && config_complete_flag_oe_o) else $error("otp load");
  AST_PROG_SLAVE: assert property (prog_cmd_accept_o |-> mode_o == 2'h3 && config_complete_flag_oe_o) else $error("prog");
  AST_PULLUP: assert property (strap_pullup_o) else $error("pullup off");
  AST_DONE_OD: assert property (!config_complete_flag_o) else $error("done driven high");
  AST_DONE_MODE: assert property (!config_complete_flag_oe_o |-> mode_o != 2'h0) else $error("done, no mode");
  AST_DONE_HOLD: assert property ($fell(config_complete_flag_oe_o) |=> (!config_complete_flag_oe_o) [*8]) else $error("done");
  AST_USER_WAIT: assert property ($rose(user_io_pins_en_o) |-> $past(config_complete_flag_oe_o, 40) == 1'b0) else $error("early io");
  AST_SECURE: assert property (otp_secured_i |=> !otp_read_allow_o) else $error("secured read");
  AST_READ_OK: assert property (otp_read_req_i && !otp_secured_i |=> otp_read_allow_o) else $error("read refused");
  AST_MODE_HOLD: assert property (mode_o != 2'h0 |=> mode_o == 2'h0 || $stable(mode_o)) else $error("mode moved");
  AST_CS: assert property (strap_cs_oe_o |-> !strap_cs_o && mode_o != 2'h3) else $error("cs drive");
  cover property ($rose(user_io_pins_en_o) && mode_o == 2'h1);
  cover property ($rose(user_io_pins_en_o) && mode_o == 2'h2);
  cover property ($rose(user_io_pins_en_o) && mode_o == 2'h3);
endmodule
bind config_mode_select_boot boot_cfg_props u_props (.*);

// File: boot_far_side.sv
// far-side model: serial flash, otp store and configuring host
`timescale 1ns/100ps
module boot_far_side (
  input wire sys_clk_i,
  input wire [1:0] mode_i,
  input wire flash_sck_i,
  input wire cs_oe_i,
  input wire otp_load_i,
  input wire user_en_i,
  output wire flash_done_o,
  output wire otp_done_o,
  output wire slave_done_o,
  output reg host_sck_o
);
  reg sck_d = 1'b0;
  reg [4:0] fcnt = 5'h0;
  reg [4:0] hcnt = 5'h0;
  reg [3:0] ocnt = 4'h0;
  assign flash_done_o = fcnt == 5'h10;
  assign otp_done_o = ocnt == 4'hA;
  assign slave_done_o = hcnt == 5'h10;
  always @(posedge sys_clk_i) begin
    sck_d <= flash_sck_i;
    if (mode_i != 2'h2) fcnt <= 5'h0;
    else if (cs_oe_i && flash_sck_i && !sck_d && !flash_done_o) fcnt <= fcnt + 5'h1;
    if (!otp_load_i) ocnt <= 4'h0;
    else if (!otp_done_o) ocnt <= ocnt + 4'h1;
  end
  // host clock stands still outside a slave load and wake-up
  initial begin
    host_sck_o = 1'b0;
    #7;
    forever begin
      #160;
      if (mode_i == 2'h3 && !user_en_i) begin
        host_sck_o = !host_sck_o;
        if (host_sck_o && !slave_done_o) hcnt = hcnt + 5'h1;
      end else begin
        host_sck_o = 1'b0;
        hcnt = 5'h0;
      end
    end
  end
endmodule

// File: tb.sv
// self-checking bench of the boot controller
`timescale 1ns/100ps
module tb;
  reg sys_clk_i = 0, resetn_i = 0, supplies_ok_i = 0, config_reset_n_i = 1, otp_enabled_i = 1, host_low = 0;
  reg otp_secured_i = 0, otp_read_req_i = 0, prog_cmd_valid_i = 0, fast_osc_req_i = 0, seen = 0;
  wire strap_cs_o, strap_cs_oe_o, strap_pullup_o, otp_load_o, otp_read_allow_o, prog_cmd_accept_o, flash_sck_o;
  wire cfg_clk_o, config_complete_flag_o, config_complete_flag_oe_o, user_io_pins_en_o;
  wire otp_load_done_i, flash_load_done_i, slave_load_done_i, host_sck_i;
  wire [1:0] mode_o;
  wire strap_cs_i = strap_cs_oe_o ? strap_cs_o : (host_low ? 1'b0 : strap_pullup_o);
  logic [1:0] q[$];
  integer n_mismatch = 0, num_checks = 0;
  config_mode_select_boot uut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .supplies_ok_i(supplies_ok_i),
    .config_reset_n_i(config_reset_n_i), .strap_cs_i(strap_cs_i), .strap_cs_o(strap_cs_o),
    .strap_cs_oe_o(strap_cs_oe_o), .strap_pullup_o(strap_pullup_o), .otp_enabled_i(otp_enabled_i),
    .otp_secured_i(otp_secured_i), .otp_load_o(otp_load_o), .otp_load_done_i(otp_load_done_i),
    .otp_read_req_i(otp_read_req_i), .otp_read_allow_o(otp_read_allow_o), .prog_cmd_valid_i(prog_cmd_valid_i),
    .prog_cmd_accept_o(prog_cmd_accept_o), .flash_sck_o(flash_sck_o), .flash_load_done_i(flash_load_done_i),
    .fast_osc_req_i(fast_osc_req_i), .host_sck_i(host_sck_i), .slave_load_done_i(slave_load_done_i),
    .mode_o(mode_o), .cfg_clk_o(cfg_clk_o), .config_complete_flag_o(config_complete_flag_o),
    .config_complete_flag_oe_o(config_complete_flag_oe_o), .user_io_pins_en_o(user_io_pins_en_o));
  boot_far_side far (.sys_clk_i(sys_clk_i), .mode_i(mode_o), .flash_sck_i(flash_sck_o), .cs_oe_i(strap_cs_oe_o),
    .otp_load_i(otp_load_o), .user_en_i(user_io_pins_en_o), .flash_done_o(flash_load_done_i),
    .otp_done_o(otp_load_done_i), .slave_done_o(slave_load_done_i), .host_sck_o(host_sck_i));
  always #20 sys_clk_i = ~sys_clk_i;
  task chk(input [1:0] a, input [1:0] e);
    num_checks++;
    if (a !== e) begin
      n_mismatch++;
      $display("mismatch %0t %h %h", $time, a, e);
    end
  endtask
  task conclude;
    if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wait_user;
    while (user_io_pins_en_o !== 1'b1) @(posedge sys_clk_i);
    repeat (2) @(posedge sys_clk_i);
  endtask
  // ****
  // result watcher and side traffic
  // ****
  // outputs are read mid-cycle, where they are settled
  always @(negedge sys_clk_i) begin
    seen <= user_io_pins_en_o === 1'b1;
    if (user_io_pins_en_o === 1'b1 && !seen) begin
      chk(mode_o, q.pop_front());
      chk({1'b0, config_complete_flag_oe_o}, 2'h0);
    end
  end
  always @(posedge sys_clk_i) begin
    #1;
    {otp_read_req_i, prog_cmd_valid_i, otp_secured_i} = 3'($urandom);
  end
  initial begin
    #1000000;
    n_mismatch++;
    conclude;
  end
  initial begin : main
    integer i, c;
    void'($urandom(49661));
    repeat (4) @(posedge sys_clk_i);
    #1 resetn_i = 1;
    repeat (20) @(posedge sys_clk_i);
    chk(mode_o, 2'h0);
    chk({1'b0, config_complete_flag_oe_o}, 2'h1);
    q.push_back(2'h1);
    #1 supplies_ok_i = 1;
    wait_user;
    for (i = 0; i < 6; i++) begin
      c = $urandom % 3;
      @(posedge sys_clk_i);
      #1 config_reset_n_i = 0;
      host_low = (c == 2);
      otp_enabled_i = (c == 0);
      fast_osc_req_i = 1'($urandom);
      repeat (4) @(posedge sys_clk_i);
      q.push_back(2'(c + 1));
      #1 config_reset_n_i = 1;
      wait_user;
    end
    conclude;
  end
endmodule
